// *** shared/dtc_params.svh ***
/*
  Constants of the dual timer/counter: register indices, reset values,
  machine-cycle phasing.
  Assumes inclusion by bare name from the RTL (dtc_phase, dtc_core); the package does not include it.
*/
`ifndef DTC_PARAMS_SVH
`define DTC_PARAMS_SVH

// ****************************************
// Register indices (byte address = 4 x index)
// ****************************************
`define DTC_IDX_CTRL     10'h088
`define DTC_IDX_MODE     10'h089
`define DTC_IDX_STAT     10'h08A
`define DTC_IDX_MASK     10'h08B
`define DTC_IDX_CNT0     10'h08C
`define DTC_IDX_CNT1     10'h08D

// ****************************************
// Reset values
// ****************************************
`define DTC_RST_MODE     8'h00
`define DTC_RST_CTRL     2'h0
`define DTC_RST_CNT      16'h0000
`define DTC_RST_FLAG     2'h0

// ****************************************
// Machine cycle phasing, in core clocks
// ****************************************
`define DTC_MC_CLKS      12
`define DTC_PH_SAMPLE    4'h9
`define DTC_PH_UPDATE    4'h4

`endif

// *** shared/dtc_pkg.sv ***
/*
  Types of the dual timer/counter.
  Needs no include file; dtc_params.svh is used by the RTL only.
*/
package dtc_pkg;

  // ****************************************
  // Count modes and per-timer configuration
  // ****************************************
  typedef enum logic [1:0] {
    DTC_M13  = 2'h0,
    DTC_M16  = 2'h1,
    DTC_M8R  = 2'h2,
    DTC_STOP = 2'h3
  } dtc_mode_t;

  typedef struct packed {
    logic      gate;
    logic      ctr;
    dtc_mode_t mode;
  } dtc_tcfg_t;

endpackage

// *** rtl/dtc_phase.sv ***
/*
  Machine cycle sequencer: divides the core clock by twelve and marks the
  sample phase and the update phase with one-cycle enables.
  Assumes a single core clock and an asynchronous active-low reset.
*/
`timescale 1ns/1ns
`include "dtc_params.svh"

module dtc_phase (
  // Clock and reset
  input  wire logic pclk,
  input  wire logic presetn,
  // Phase enables
  output logic      sample_phase,
  output logic      update_phase
);

  logic [3:0] ph_ff;
  logic [3:0] nxt_ph;

  assign nxt_ph = (ph_ff == 4'(`DTC_MC_CLKS - 1)) ? 4'h0 : ph_ff + 4'h1;
  assign sample_phase = (ph_ff == `DTC_PH_SAMPLE);
  assign update_phase = (ph_ff == `DTC_PH_UPDATE);

  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      ph_ff <= 4'h0;
    end else begin
      ph_ff <= nxt_ph;
    end
  end

endmodule

// *** rtl/dtc_edge.sv ***
/*
  Event pin falling-edge detector, sampled once per machine cycle.
  Assumes the pin is synchronous to the core clock and each level is held
  for at least one machine cycle.
*/
`timescale 1ns/1ns

module dtc_edge (
  // Clock and reset
  input  wire logic pclk,
  input  wire logic presetn,
  // Sampling
  input  wire logic sample_phase,
  input  wire logic pin,
  // Result, held one machine cycle
  output logic      fall_seen
);

  logic prev_ff;
  logic fall_ff;

  assign fall_seen = fall_ff;

  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      prev_ff <= 1'b0;
      fall_ff <= 1'b0;
    end else if (sample_phase) begin
      prev_ff <= pin;
      fall_ff <= prev_ff & ~pin;
    end
  end

endmodule

// *** rtl/dtc_core.sv ***
/*
  Two 16-bit timer/counters with a shared mode register, APB slave,
  overflow status with mask and one interrupt line.
  Assumes APB signals and event/interrupt pins synchronous to pclk.
*/
// The implementer's own choice: the APB slave port.
`timescale 1ns/1ns
`include "dtc_params.svh"

module dtc_core
  import dtc_pkg::*;
(
  // Clock and reset
  input  wire logic        pclk,
  input  wire logic        presetn,
  // APB slave
  input  wire logic        psel,
  input  wire logic        penable,
  input  wire logic        pwrite,
  input  wire logic [11:0] paddr,
  input  wire logic [31:0] pwdata,
  output logic      [31:0] prdata,
  output logic             pready,
  output logic             pslverr,
  // Event and gate pins
  input  wire logic        event_input_0,
  input  wire logic        event_input_1,
  input  wire logic        ext_irq_pin_0,
  input  wire logic        ext_irq_pin_1,
  // Interrupt
  output logic             irq
);

  // ****************************************
  // Functions
  // ****************************************
  function automatic logic dtc_hit(input logic [11:0] a,
                                   input logic [9:0]  idx);
    dtc_hit = (a[11:2] == idx) && (a[1:0] == 2'h0);
  endfunction

  // Returns {overflow, next count} for one count step
  function automatic logic [16:0] dtc_step(input dtc_mode_t   m,
                                           input logic [15:0] c);
    logic [5:0] pre;
    logic [8:0] hi;
    logic [8:0] lo;
    pre = {1'b0, c[4:0]} + 6'h01;
    hi  = {1'b0, c[15:8]} + {8'h00, pre[5]};
    lo  = {1'b0, c[7:0]} + 9'h001;
    dtc_step = {1'b0, c};
    case (m)
      DTC_M13: begin
        dtc_step = {hi[8], hi[7:0], c[7:5], pre[4:0]};
      end
      DTC_M16: begin
        dtc_step = {1'b0, c} + 17'h00001;
      end
      DTC_M8R: begin
        dtc_step = lo[8] ? {1'b1, c[15:8], c[15:8]}
                         : {1'b0, c[15:8], lo[7:0]};
      end
      default: begin
        dtc_step = {1'b0, c};
      end
    endcase
  endfunction

  // ****************************************
  // Registers and wires
  // ****************************************
  logic [7:0]  mode_ff;
  logic [1:0]  ctrl_ff;
  logic [1:0]  stat_ff;
  logic [1:0]  mask_ff;
  logic [15:0] cnt0_ff;
  logic [15:0] cnt1_ff;
  logic [31:0] rdata_ff;

  logic [7:0]  nxt_mode;
  logic [1:0]  nxt_ctrl;
  logic [1:0]  nxt_stat;
  logic [1:0]  nxt_mask;
  logic [15:0] nxt_cnt0;
  logic [15:0] nxt_cnt1;
  logic [31:0] nxt_rdata;

  logic        smp;
  logic        upd;
  logic        fall0;
  logic        fall1;

  dtc_tcfg_t   cfg0;
  dtc_tcfg_t   cfg1;

  // ****************************************
  // Machine cycle and edge detection
  // ****************************************
  // twelve clock cycle
  dtc_phase u_phase (
    .pclk         (pclk),
    .presetn      (presetn),
    .sample_phase (smp),
    .update_phase (upd)
  );

  dtc_edge u_edge0 (
    .pclk         (pclk),
    .presetn      (presetn),
    .sample_phase (smp),
    .pin          (event_input_0),
    .fall_seen    (fall0)
  );

  dtc_edge u_edge1 (
    .pclk         (pclk),
    .presetn      (presetn),
    .sample_phase (smp),
    .pin          (event_input_1),
    .fall_seen    (fall1)
  );

  // ****************************************
  // APB decode
  // ****************************************
  wire setup    = psel & ~penable;
  wire access   = psel & penable;
  wire hit_ctrl = dtc_hit(paddr, `DTC_IDX_CTRL);
  wire hit_mode = dtc_hit(paddr, `DTC_IDX_MODE);
  wire hit_stat = dtc_hit(paddr, `DTC_IDX_STAT);
  wire hit_mask = dtc_hit(paddr, `DTC_IDX_MASK);
  wire hit_cnt0 = dtc_hit(paddr, `DTC_IDX_CNT0);
  wire hit_cnt1 = dtc_hit(paddr, `DTC_IDX_CNT1);
  wire hit_any  = hit_ctrl | hit_mode | hit_stat | hit_mask
                | hit_cnt0 | hit_cnt1;
  wire wr       = access & pwrite & hit_any;
  wire wr_cnt0  = wr & hit_cnt0;
  wire wr_cnt1  = wr & hit_cnt1;

  assign pready  = 1'b1;
  assign pslverr = access & ~hit_any;
  assign prdata  = rdata_ff;

  // Read data is captured in the setup cycle, ready in the access cycle
  assign nxt_rdata = !setup   ? rdata_ff
                   : hit_ctrl ? {30'h0, ctrl_ff}
                   : hit_mode ? {24'h0, mode_ff}
                   : hit_stat ? {30'h0, stat_ff}
                   : hit_mask ? {30'h0, mask_ff}
                   : hit_cnt0 ? {16'h0, cnt0_ff}
                   : hit_cnt1 ? {16'h0, cnt1_ff}
                   : 32'h00000000;

  // ****************************************
  // Configuration
  // ****************************************
  // mode, control and mask register writes
  assign nxt_mode = (wr & hit_mode) ? pwdata[7:0] : mode_ff;
  assign nxt_ctrl = (wr & hit_ctrl) ? pwdata[1:0] : ctrl_ff;
  assign nxt_mask = (wr & hit_mask) ? pwdata[1:0] : mask_ff;

  assign cfg0 = dtc_tcfg_t'(mode_ff[3:0]);
  assign cfg1 = dtc_tcfg_t'(mode_ff[7:4]);

  // ****************************************
  // Count engines
  // ****************************************
  // gate qualification
  wire run0 = ctrl_ff[0] & (~cfg0.gate | ext_irq_pin_0);
  wire run1 = ctrl_ff[1] & (~cfg1.gate | ext_irq_pin_1);

  wire tick0 = upd & run0 & (cfg0.ctr ? fall0 : 1'b1);
  wire tick1 = upd & run1 & (cfg1.ctr ? fall1 : 1'b1);

  wire [16:0] step0 = dtc_step(cfg0.mode, cnt0_ff);
  wire [16:0] step1 = dtc_step(cfg1.mode, cnt1_ff);

  assign nxt_cnt0 = wr_cnt0 ? pwdata[15:0]
                  : tick0   ? step0[15:0]
                  : cnt0_ff;
  assign nxt_cnt1 = wr_cnt1 ? pwdata[15:0]
                  : tick1   ? step1[15:0]
                  : cnt1_ff;

  wire ovf0 = tick0 & step0[16] & ~wr_cnt0;
  wire ovf1 = tick1 & step1[16] & ~wr_cnt1;

  // ****************************************
  // Status and interrupt
  // ****************************************
  // sticky flags, set wins over clear
  wire [1:0] clr = (wr & hit_stat) ? pwdata[1:0] : 2'h0;
  assign nxt_stat = (stat_ff & ~clr) | {ovf1, ovf0};
  assign irq      = |(stat_ff & mask_ff);

  // ****************************************
  // Flip-flops
  // ****************************************
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      mode_ff  <= `DTC_RST_MODE;
      ctrl_ff  <= `DTC_RST_CTRL;
      stat_ff  <= `DTC_RST_FLAG;
      mask_ff  <= `DTC_RST_FLAG;
      rdata_ff <= 32'h00000000;
    end else begin
      mode_ff  <= nxt_mode;
      ctrl_ff  <= nxt_ctrl;
      stat_ff  <= nxt_stat;
      mask_ff  <= nxt_mask;
      rdata_ff <= nxt_rdata;
    end
  end

  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      cnt0_ff <= `DTC_RST_CNT;
      cnt1_ff <= `DTC_RST_CNT;
    end else begin
      cnt0_ff <= nxt_cnt0;
      cnt1_ff <= nxt_cnt1;
    end
  end

  // ****************************************
  // Assertions
  // ****************************************
  default clocking dtc_cb @(posedge pclk);
  endclocking
  default disable iff (!presetn);

  machine_cycle_a: assert property (
    upd |-> ##12 upd)
    else $error("update phase not twelve clocks apart");

  timer_tick_a: assert property (
    upd && run0 && !cfg0.ctr && cfg0.mode == DTC_M16 && !wr_cnt0
    |=> cnt0_ff == $past(cnt0_ff) + 16'h0001)
    else $error("timer 0 did not step on machine cycle");

  sample_point_a: assert property (
    $changed(fall1) |-> $past(smp))
    else $error("event pin judged outside sample phase");

  event_count_a: assert property (
    smp && run1 && cfg1.ctr && cfg1.mode == DTC_M16
    && $past(event_input_1, 12) && !event_input_1
    ##1 (!wr_cnt1 && !smp)[*7] ##1 !wr_cnt1
    |=> cnt1_ff == $past(cnt1_ff, 8) + 16'h0001)
    else $error("event count not visible at next update");

  no_event_a: assert property (
    cfg1.ctr && !fall1 && !wr_cnt1 |=> $stable(cnt1_ff))
    else $error("counter moved without a falling edge");

  event_rate_a: assert property (
    tick1 && cfg1.ctr ##12 cfg1.ctr |-> !tick1)
    else $error("event counted too soon after the last");

  gate_hold_a: assert property (
    cfg1.gate && !ext_irq_pin_1 && !wr_cnt1 |=> $stable(cnt1_ff))
    else $error("gated timer 1 counted with pin low");

  stop_mode_a: assert property (
    cfg1.mode == DTC_STOP && !wr_cnt1 |=> $stable(cnt1_ff))
    else $error("timer 1 counted in stop mode");

  reload_a: assert property (
    tick0 && cfg0.mode == DTC_M8R && cnt0_ff[7:0] == 8'hFF && !wr_cnt0
    |=> cnt0_ff[7:0] == cnt0_ff[15:8] && stat_ff[0])
    else $error("low byte not reloaded on overflow");

  prescale_a: assert property (
    tick0 && cfg0.mode == DTC_M13 && cnt0_ff[4:0] != 5'h1F && !wr_cnt0
    |=> $stable(cnt0_ff[15:8]))
    else $error("high byte moved before prescaler wrap");

  ovf_flag_a: assert property (
    (ovf0 |=> stat_ff[0]) and (ovf1 |=> stat_ff[1]))
    else $error("overflow did not set its flag");

  stat_clear_a: assert property (
    wr && hit_stat && pwdata[0] && !ovf0 |=> !stat_ff[0])
    else $error("status bit not cleared by writing one");

  stat_sticky_a: assert property (
    stat_ff[0] && !(wr && hit_stat && pwdata[0]) |=> stat_ff[0])
    else $error("overflow flag dropped without a clear");

  mode_write_a: assert property (
    wr && hit_mode |=> mode_ff == $past(pwdata[7:0]))
    else $error("mode register write lost");

  mode_reset_a: assert property (
    $rose(presetn) |-> mode_ff == 8'h00)
    else $error("mode register not zero after reset");

  ovf_seen_c: cover property (ovf1 && cfg1.mode == DTC_M13);
  reload_seen_c: cover property (ovf0 && cfg0.mode == DTC_M8R);
  event_seen_c: cover property (tick1 && cfg1.ctr && cfg1.gate);
  irq_seen_c: cover property ($rose(irq));

endmodule

// *** verification/dtc_pins_model.sv ***
/*
  Pin model: event and gate pins seen by the timer core.
  Assumes the bench calls its tasks; pins change after rising edges.
*/
`timescale 1ns/1ns

module dtc_pins_model (
  // Clock
  input  wire logic pclk,
  // Pins
  output logic      event_input_0,
  output logic      event_input_1,
  output logic      ext_irq_pin_0,
  output logic      ext_irq_pin_1
);
  initial begin
    event_input_0 = 1'b1;
    event_input_1 = 1'b1;
    ext_irq_pin_0 = 1'b1;
    ext_irq_pin_1 = 1'b0;
  end

  task automatic set_gate(input logic v);
    @(posedge pclk);
    ext_irq_pin_1 <= v;
  endtask

  // each level held one machine cycle
  task automatic pulses(input int n);
    @(posedge pclk);
    repeat (n) begin
      event_input_0 <= 1'b0;
      event_input_1 <= 1'b0;
      repeat (12) @(posedge pclk);
      event_input_0 <= 1'b1;
      event_input_1 <= 1'b1;
      repeat (12) @(posedge pclk);
    end
  endtask
endmodule

// *** verification/dtc_core_tb.sv ***
/*
  Testbench of the dual timer core: APB tasks and directed checks.
  Assumes dtc_core and dtc_pins_model are compiled first.
*/
`timescale 1ns/1ns

module dtc_core_tb;
  logic        pclk;
  logic        presetn;
  logic        psel;
  logic        penable;
  logic        pwrite;
  logic [11:0] paddr;
  logic [31:0] pwdata;
  logic [31:0] prdata;
  logic [31:0] rd;
  logic        pready;
  logic        pslverr;
  logic        irq;
  logic        err_seen;
  logic        ev0;
  logic        ev1;
  logic        g0;
  logic        g1;
  int          fails = 0;
  int          num_checks = 0;
  int          cycles = 0;

  dtc_core dut (.pclk(pclk), .presetn(presetn), .psel(psel),
    .penable(penable), .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata),
    .prdata(prdata), .pready(pready), .pslverr(pslverr),
    .event_input_0(ev0), .event_input_1(ev1), .ext_irq_pin_0(g0),
    .ext_irq_pin_1(g1), .irq(irq));

  dtc_pins_model pins (.pclk(pclk), .event_input_0(ev0),
    .event_input_1(ev1), .ext_irq_pin_0(g0), .ext_irq_pin_1(g1));

  // ****************************************
  // Clock, timeout, verdict
  // ****************************************
  initial begin
    pclk = 1'b0;
    forever #5 pclk = ~pclk;
  end

  task automatic close_out;
    if (fails == 0 && num_checks > 0) begin
      $display("Finished cleanly");
    end else begin
      $display("Finished with errors");
    end
    $finish;
  endtask

  always @(posedge pclk) begin
    cycles++;
    if (cycles == 5000) begin
      fails++;
      $display("mismatch at %0t: timeout", $time);
      close_out();
    end
  end

  // ****************************************
  // Bus and compare tasks
  // ****************************************
  task automatic apb(input logic wr, input logic [11:0] a,
                     input logic [31:0] d);
    @(posedge pclk);
    psel <= 1'b1;
    pwrite <= wr;
    paddr <= a;
    pwdata <= d;
    @(posedge pclk);
    penable <= 1'b1;
    do @(posedge pclk); while (pready !== 1'b1);
    rd = prdata;
    err_seen = pslverr;
    psel <= 1'b0;
    penable <= 1'b0;
  endtask

  task automatic check(input logic [31:0] got, input logic [31:0] exp);
    num_checks++;
    if (got !== exp) begin
      fails++;
      $display("mismatch at %0t: got %h exp %h", $time, got, exp);
    end
  endtask

  task automatic rd_chk(input logic [11:0] a, input logic [31:0] exp);
    apb(1'b0, a, 32'h0);
    check(rd, exp);
  endtask

  // Two reads 120 clocks apart differ by n steps
  task automatic rate_chk(input logic [11:0] a, input logic [31:0] n);
    logic [31:0] base;
    apb(1'b0, a, 32'h0);
    base = rd;
    repeat (117) @(posedge pclk);
    rd_chk(a, base + n);
  endtask

  // Mode m for exactly twelve clocks on the count at a, one step
  task automatic one_step(input logic [11:0] a, input logic [7:0] m,
                          input logic [15:0] init, input logic [15:0] exp);
    apb(1'b1, 12'h224, 32'h33);
    apb(1'b1, a, {16'h0, init});
    apb(1'b1, 12'h224, {24'h0, m});
    repeat (9) @(posedge pclk);
    apb(1'b1, 12'h224, 32'h33);
    rd_chk(a, {16'h0, exp});
  endtask

  // ****************************************
  // Main sequence
  // ****************************************
  initial begin
    presetn = 1'b0;
    psel = 1'b0;
    penable = 1'b0;
    pwrite = 1'b0;
    paddr = 12'h000;
    pwdata = 32'h0;
    repeat (10) @(posedge pclk);
    presetn <= 1'b1;
    rd_chk(12'h224, 32'h0);
    rd_chk(12'h230, 32'h0);
    apb(1'b0, 12'h300, 32'hFFFF_FFFF);
    check({31'h0, err_seen}, 32'h1);
    check(rd, 32'h0);
    apb(1'b1, 12'h224, 32'hA5);
    rd_chk(12'h224, 32'hA5);
    apb(1'b1, 12'h224, 32'h31);
    apb(1'b1, 12'h220, 32'h3);
    rate_chk(12'h230, 32'd10);
    apb(1'b1, 12'h22C, 32'h1);
    apb(1'b1, 12'h230, 32'hFFFF);
    repeat (24) @(posedge pclk);
    rd_chk(12'h228, 32'h1);
    @(negedge pclk);
    check({31'h0, irq}, 32'h1);
    apb(1'b1, 12'h22C, 32'h0);
    @(negedge pclk);
    check({31'h0, irq}, 32'h0);
    apb(1'b1, 12'h228, 32'h1);
    rd_chk(12'h228, 32'h0);
    one_step(12'h234, 8'h03, 16'h00FF, 16'h01E0);
    one_step(12'h234, 8'h03, 16'hFFFF, 16'h00E0);
    one_step(12'h234, 8'h13, 16'h00FF, 16'h0100);
    one_step(12'h234, 8'h23, 16'h80FF, 16'h8080);
    one_step(12'h234, 8'h33, 16'h1234, 16'h1234);
    one_step(12'h230, 8'h32, 16'h40FF, 16'h4040);
    rd_chk(12'h228, 32'h3);
    apb(1'b1, 12'h224, 32'h93);
    rate_chk(12'h234, 32'd0);
    pins.set_gate(1'b1);
    rate_chk(12'h234, 32'd10);
    apb(1'b1, 12'h224, 32'hDD);
    apb(1'b1, 12'h230, 32'h0);
    apb(1'b1, 12'h234, 32'h0);
    pins.pulses(5);
    repeat (30) @(posedge pclk);
    rd_chk(12'h234, 32'd5);
    rd_chk(12'h230, 32'd5);
    close_out();
  end
endmodule
